// ===== logic/wiper_pkg.sv
// Purpose: shared constants and types for the wiper command core
// Assumes: 16-bit frames, command byte first, MSB first
// Notes: command codes are the upper byte of a frame
package wiper_pkg;
   localparam int CODE_W = 6;
   localparam int TAPS = 64;
   localparam int FRAME_W = 16;
   localparam logic [5:0] CODE_MAX = 6'h3f;
   localparam logic [5:0] CODE_RST = 6'h00;
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_RESTORE = 8'h10;
   localparam logic [7:0] CMD_STORE = 8'h20;
   localparam logic [7:0] CMD_READ = 8'ha0;
   localparam logic [7:0] CMD_WRITE = 8'hb0;
   localparam logic [7:0] CMD_INC = 8'he0;
   localparam logic [3:0] BIT_CNT_LAST = 4'hf;
   localparam logic [15:0] ECHO_RST = 16'h0000;
   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] data;
   } frame_t;

   typedef enum logic [1:0] {
      ST_BOOT,
      ST_RUN
   } core_state_t;
endpackage

// ===== logic/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to i_clk
// Notes: output changes once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_d,
   output logic o_q
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic q_r;
   wire agree = (s2_r == s3_r);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q_r <= RST_VAL;
      end else begin
         s1_r <= i_d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) begin
            q_r <= s3_r;
         end
      end
   end

   assign o_q = q_r;
endmodule // pin_sync

// ===== logic/quad_wiper_serial_command_core.sv
// Purpose: serial command core for the first wiper channel
// Assumes: SPI mode 0, frame framed by active-low select, 16 bits
// Notes: frame capture on serial clock, execution on i_clk
`timescale 1ns/1ns
//
// Contract
// - Hold a 6-bit code per channel, decode the first channel one-hot to 64 taps.
// - Code zero selects the tap at terminal B end.
// - Each code step moves one tap away from B, up to 63.
// - Command B0 loads the low 6 bits of the data byte into the first wiper code.
// - Command E0 raises the first wiper code by one each frame until it reaches 63.
// - Command 20 copies the first wiper code into saved storage.
// - Write-protect low blocks command 20 stores into saved storage; reset still clears the saved copy.
// - Reload code from saved copy at power-on, preset strobe, restore.
// - Command 10 moves saved value into the first wiper code.
// - Increment and similar commands ignore the frame data byte.
// - No-operation frame shifts out a full 16-bit word.
module quad_wiper_serial_command_core
   import wiper_pkg::*;
#(
   parameter int CHANNELS = 4
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe,
   input wire logic i_write_protect_n,
   input wire logic i_preset_restore_n,
   output logic [TAPS-1:0] o_first_wiper_terminal,
   output logic [CHANNELS*CODE_W-1:0] o_wiper_code_register,
   output logic [CODE_W-1:0] o_first_wiper_saved_code
);
   if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_channels
      $error("CHANNELS must be 1 to 4");
   end

   // ****************************************************
   // Link domain: shift in, shift out
   // ****************************************************
   logic [FRAME_W-1:0] rx_sh_r;
   logic [3:0] bit_cnt_r;
   logic [FRAME_W-1:0] rx_word_r;
   logic rx_tgl_r;
   logic [FRAME_W-1:0] tx_sh_r;
   logic [3:0] tx_idx_r;
   logic [FRAME_W-1:0] echo_sync_r;
   wire [FRAME_W-1:0] rx_full = {rx_sh_r[FRAME_W-2:0], i_mosi};
   wire frame_done = (bit_cnt_r == BIT_CNT_LAST);

   // Counter cleared by select, since the serial clock stops between frames
   always_ff @(posedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         bit_cnt_r <= 4'h0;
      end else begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge i_sclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_sh_r <= ECHO_RST;
         rx_word_r <= ECHO_RST;
         rx_tgl_r <= 1'b0;
      end else begin
         rx_sh_r <= rx_full;
         if (frame_done) begin
            rx_word_r <= rx_full;
            rx_tgl_r <= ~rx_tgl_r;
         end
      end
   end

   // Own falling-edge index, so the output never moves on a rising edge
   wire tx_load = (tx_idx_r == 4'h0);
   always_ff @(negedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         tx_idx_r <= 4'h0;
         tx_sh_r <= 16'h0000;
      end else begin
         tx_idx_r <= tx_idx_r + 4'h1;
         tx_sh_r <= tx_load ? {echo_sync_r[FRAME_W-2:0], 1'b0} :
                    {tx_sh_r[FRAME_W-2:0], 1'b0};
      end
   end

   assign o_miso = tx_load ? echo_sync_r[FRAME_W-1] :
                   tx_sh_r[FRAME_W-1];
   assign o_miso_oe = ~i_cs_n;

   // ****************************************************
   // Crossing: toggle for frame, word stable while toggle settles
   // ****************************************************
   logic tg1_r;
   logic tg2_r;
   logic tg3_r;
   frame_t frame_r;
   logic frame_pls;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tg1_r <= 1'b0;
         tg2_r <= 1'b0;
         tg3_r <= 1'b0;
         frame_r <= '0;
      end else begin
         tg1_r <= rx_tgl_r;
         tg2_r <= tg1_r;
         tg3_r <= tg2_r;
         if (tg2_r != tg3_r) begin
            frame_r <= rx_word_r;
         end
      end
   end
   assign frame_pls = (tg2_r != tg3_r);

   // ****************************************************
   // Pin inputs
   // ****************************************************
   logic wp_n_s;
   logic pr_n_s;
   logic pr_n_d_r;
   pin_sync #(.RST_VAL(1'b1)) u_wp_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_d(i_write_protect_n),
      .o_q(wp_n_s)
   );
   pin_sync #(.RST_VAL(1'b1)) u_pr_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_d(i_preset_restore_n),
      .o_q(pr_n_s)
   );
   wire pr_strobe = pr_n_d_r & ~pr_n_s;

   // ****************************************************
   // Command execution
   // ****************************************************
   core_state_t state_r;
   logic exec_r;
   logic [CODE_W-1:0] code_r [CHANNELS];
   logic [CODE_W-1:0] saved_r;
   logic [FRAME_W-1:0] echo_r;
   logic [FRAME_W-1:0] echo_nxt;
   logic [CODE_W-1:0] code0_nxt;

   // Execution runs one cycle after capture so frame_r holds the word
   wire [7:0] cmd = frame_r.cmd;
   wire is_write = exec_r && (cmd == CMD_WRITE);
   wire is_inc = exec_r && (cmd == CMD_INC);
   wire is_store = exec_r && (cmd == CMD_STORE) && wp_n_s;
   wire is_restore = exec_r && (cmd == CMD_RESTORE);
   wire is_read = exec_r && (cmd == CMD_READ);
   wire boot = (state_r == ST_BOOT);
   wire reload = boot | pr_strobe | is_restore;
   wire at_max = (code_r[0] == CODE_MAX);
   // Data byte never looked at for increment
   wire [CODE_W-1:0] inc_val = at_max ? CODE_MAX :
                               code_r[0] + 6'h01;

   assign code0_nxt = reload ? saved_r :
                      is_write ? frame_r.data[CODE_W-1:0] :
                      is_inc ? inc_val : code_r[0];

   // Read command returns the first code in the low byte
   assign echo_nxt = is_read ? {CMD_READ, 2'b00, code0_nxt} :
                     frame_r;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= ST_BOOT;
         exec_r <= 1'b0;
         pr_n_d_r <= 1'b1;
         saved_r <= CODE_RST;
         echo_r <= ECHO_RST;
      end else begin
         exec_r <= frame_pls;
         pr_n_d_r <= pr_n_s;
         case (state_r)
            ST_BOOT: state_r <= ST_RUN;
            ST_RUN: state_r <= ST_RUN;
            default: state_r <= ST_BOOT;
         endcase
         if (is_store) begin
            saved_r <= code_r[0];
         end
         if (exec_r) begin
            echo_r <= echo_nxt;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         code_r[0] <= CODE_RST;
      end else begin
         code_r[0] <= code0_nxt;
      end
   end

   genvar g;
   generate
      for (g = 1; g < CHANNELS; g++) begin : g_ch
         // Other channels hold reset code; no command reaches them here
         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               code_r[g] <= CODE_RST;
            end else begin
               code_r[g] <= code_r[g];
            end
         end
      end
      for (g = 0; g < CHANNELS; g++) begin : g_out
         assign o_wiper_code_register[g*CODE_W +: CODE_W] =
            code_r[g];
      end
   endgenerate

   // Captured at select fall: the serial clock is stopped between
   // frames, and the frame gap leaves echo settled for two cycles
   always_ff @(negedge i_cs_n or negedge i_rstn) begin
      if (!i_rstn) begin
         echo_sync_r <= ECHO_RST;
      end else begin
         echo_sync_r <= echo_r;
      end
   end

   // ****************************************************
   // Tap decode
   // ****************************************************
   logic [TAPS-1:0] tap_r;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tap_r <= {{(TAPS-1){1'b0}}, 1'b1};
      end else begin
         tap_r <= {{(TAPS-1){1'b0}}, 1'b1} << code0_nxt;
      end
   end
   assign o_first_wiper_terminal = tap_r;
   assign o_first_wiper_saved_code = saved_r;
endmodule // quad_wiper_serial_command_core

// ===== bench/wiper_core_asserts.sv
// Purpose: port-level checks for the wiper command core
// Assumes: one i_clk domain, async active-low reset
// Notes: tap output moves in the same cycle as the code
`timescale 1ns/1ns
module wiper_core_asserts
   import wiper_pkg::*;
#(
   parameter int CHANNELS = 4
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_cs_n,
   input wire logic i_write_protect_n,
   input wire logic i_preset_restore_n,
   input wire logic o_miso_oe,
   input wire logic [TAPS-1:0] o_first_wiper_terminal,
   input wire logic [CHANNELS*CODE_W-1:0] o_wiper_code_register,
   input wire logic [CODE_W-1:0] o_first_wiper_saved_code
);
   wire logic [CODE_W-1:0] c = o_wiper_code_register[CODE_W-1:0];
   wire logic [CODE_W-1:0] s = o_first_wiper_saved_code;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   a_tap_onehot: assert property ($onehot(o_first_wiper_terminal))
      else $error("tap select not one-hot");
   a_tap_code: assert property (
      o_first_wiper_terminal == (64'h1 << c))
      else $error("tap does not follow code");
   a_other_idle: assert property (
      o_wiper_code_register[CHANNELS*CODE_W-1:CODE_W] == '0)
      else $error("unused channel code moved");
   // Sync plus filter may take several cycles to see the pin
   a_wp_block: assert property (
      (!i_write_protect_n)[*6] |=> $stable(s))
      else $error("saved code changed while protected");
   a_code_quiet: assert property ($changed(c) |-> i_cs_n)
      else $error("code changed inside a frame");
   a_store_copy: assert property ($changed(s) |-> s == c)
      else $error("saved code differs from code");
   a_preset_load: assert property (
      $fell(i_preset_restore_n) |-> ##[1:8] c == s)
      else $error("preset strobe did not reload code");
   a_oe_select: assert property (o_miso_oe == !i_cs_n)
      else $error("output enable does not follow select");
endmodule // wiper_core_asserts
bind quad_wiper_serial_command_core wiper_core_asserts #(
   .CHANNELS(CHANNELS)
) i_wiper_core_asserts (
   .i_clk(i_clk),
   .i_rstn(i_rstn),
   .i_cs_n(i_cs_n),
   .i_write_protect_n(i_write_protect_n),
   .i_preset_restore_n(i_preset_restore_n),
   .o_miso_oe(o_miso_oe),
   .o_first_wiper_terminal(o_first_wiper_terminal),
   .o_wiper_code_register(o_wiper_code_register),
   .o_first_wiper_saved_code(o_first_wiper_saved_code)
);

// ===== bench/spi_host_model.sv
// Purpose: serial host sending 16-bit command frames
// Assumes: mode 0, 15 ns serial clock only inside frames
// Notes: data line flips when idle so stale bits never match
`timescale 1ns/1ns
module spi_host_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_mosi,
   input wire logic i_miso
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      o_cs_n = 1'b0;
      o_mosi = w[15];
      #7;
      for (int i = 15; i >= 0; i--) begin
         o_sclk = 1'b1;
         r[i] = i_miso;
         #8;
         o_sclk = 1'b0;
         if (i > 0) o_mosi = w[i-1];
         #7;
      end
      o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
   endtask
endmodule // spi_host_model

// ===== bench/quad_wiper_serial_command_core_tb.sv
// Purpose: self-checking bench for the wiper command core
// Assumes: 10 MHz core clock, host model on the serial side
// Notes: fixed settle wait covers sync and execute latency
`timescale 1ns/1ns
module quad_wiper_serial_command_core_tb;
   import wiper_pkg::*;
   logic i_clk, i_rstn, wp_n, pr_n;
   wire logic sclk, cs_n, mosi, miso, miso_oe;
   wire logic [TAPS-1:0] tap;
   wire logic [23:0] codes;
   wire logic [CODE_W-1:0] saved;
   logic [15:0] rx;
   int errors = 0;
   int n_compared = 0;
   quad_wiper_serial_command_core i_quad_wiper_serial_command_core (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
      .i_write_protect_n(wp_n), .i_preset_restore_n(pr_n),
      .o_first_wiper_terminal(tap), .o_wiper_code_register(codes),
      .o_first_wiper_saved_code(saved));
   spi_host_model i_spi_host_model (.o_sclk(sclk), .o_cs_n(cs_n),
      .o_mosi(mosi), .i_miso(miso));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task automatic check(input string nm, input logic [63:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Ten cycles exceed the toggle crossing and the update latency
   task automatic frame(input logic [15:0] w);
      i_spi_host_model.xfer(w, rx);
      repeat (10) @(negedge i_clk);
   endtask
   task automatic t_boot();
      check("code", codes, 0);
      check("tap", tap, 64'h1);
   endtask
   task automatic t_write_inc();
      frame(16'hb010);
      check("code", codes[5:0], 6'h10);
      check("tap", tap, 64'h1 << 16);
      frame(16'he0ff);
      check("code", codes[5:0], 6'h11);
      check("echo", rx, 16'hb010);
      frame(16'he000);
      check("code", codes[5:0], 6'h12);
      check("echo", rx, 16'he0ff);
   endtask
   task automatic t_sat();
      frame(16'hb03f);
      frame(16'he055);
      check("code", codes, 24'h3f);
      check("tap", tap, 64'h1 << 63);
   endtask
   task automatic t_store();
      wp_n = 1'b0;
      frame(16'h2000);
      check("saved", saved, 6'h00);
      wp_n = 1'b1;
      frame(16'h2000);
      check("saved", saved, 6'h3f);
   endtask
   task automatic t_restore();
      frame(16'hb005);
      frame(16'h1000);
      check("code", codes[5:0], 6'h3f);
      frame(16'hb001);
      check("code", codes[5:0], 6'h01);
      pr_n = 1'b0;
      repeat (10) @(negedge i_clk);
      pr_n = 1'b1;
      repeat (10) @(negedge i_clk);
      check("code", codes[5:0], 6'h3f);
   endtask
   task automatic t_read();
      frame(16'ha000);
      check("echo", rx, 16'hb001);
      frame(16'h0000);
      check("read", rx, 16'ha03f);
   endtask
   task automatic t_rerst();
      i_rstn = 1'b0;
      repeat (3) @(negedge i_clk);
      i_rstn = 1'b1;
      repeat (4) @(negedge i_clk);
      check("saved", saved, 6'h00);
      check("code", codes, 0);
   endtask
   initial begin
      i_rstn = 1'b0;
      wp_n = 1'b1;
      pr_n = 1'b1;
      repeat (10) @(negedge i_clk);
      i_rstn = 1'b1;
      repeat (10) @(negedge i_clk);
      t_boot();
      t_write_inc();
      t_sat();
      t_store();
      t_restore();
      t_read();
      t_rerst();
      finish_test();
   end
   initial begin
      #2000000;
      errors++;
      finish_test();
   end
endmodule // quad_wiper_serial_command_core_tb
